// ==== srl_pkg.sv ====
// Constants, encodings and reset values of the status relay logic unit.
// Assumes one 100 MHz clock and registers reached over AHB-Lite.
// Operation
// - Four relays, default sources alarm/OK/wind/mains
// - Emergency power drops only OK and mains
// - Per relay condition and delay, 0..3600 s
// - Per relay hold, 0 unlimited, else 1..3600 s
// - NOT, AND, OR and grouping supported
// - Term is optional negation, source, item
// - Sources: all, class, central, numbered instance
// - Items depend on source class
// - Everything strictly two-valued
// - NOT inverts, AND both, OR either
// - Relay strictly on or off from result
// - Relay on while true or hold time
// - Hold ignores condition until it expires
// - Emergency drop-out and sources are configurable
// - Relay-on, fault and OK indicators driven
package srl_pkg;
  localparam int RELAYS = 4;
  localparam int CLK_HZ = 100_000_000;
  localparam int SECOND_S = 1;
  localparam int TICK_CYCLES = CLK_HZ * SECOND_S;
  localparam int TICK_CNT_W = 27;
  localparam int TIME_W = 12;
  localparam logic [TIME_W-1:0] MAX_SECONDS = 12'hE10;
  // Condition program: eight postfix instructions of 16 bits per relay
  localparam int INSN_W = 16;
  localparam int INSNS = 8;
  localparam int PROG_W = INSN_W * INSNS;
  localparam int PROG_WORDS = 4;
  localparam int OP_LSB = 13;
  localparam int NEG_BIT = 12;
  localparam int SRC_LSB = 4;
  localparam int ITEM_LSB = 0;
  localparam logic [2:0] OP_END = 3'h0;
  localparam logic [2:0] OP_TERM = 3'h1;
  localparam logic [2:0] OP_AND = 3'h2;
  localparam logic [2:0] OP_OR = 3'h3;
  localparam logic [2:0] OP_NOT = 3'h4;
  // Sources: each owns a slice of 16 status items
  localparam int SRC_ALL = 0;
  localparam int SRC_ALL_SENSOR = 1;
  localparam int SRC_ALL_MOTOR = 2;
  localparam int SRC_CENTRAL = 3;
  localparam int SRC_SENSOR1 = 4;
  localparam int SRC_MOTOR1 = 6;
  localparam int SRC_MESSAGE1 = 8;
  localparam int SOURCES = 9;
  localparam int ITEMS = 16;
  localparam int TAB_W = SOURCES * ITEMS;
  localparam int SENSORS = 2;
  localparam int MOTORS = 2;
  // Item codes; the meaning of a code depends on the source class
  localparam int ITM_FAIL = 0;
  localparam int ITM_MAINS_FAIL = 1;
  localparam int ITM_WIND = 2;
  localparam int ITM_SIGNAL1 = 3;
  localparam int ITM_ALARM = 1;
  localparam int ITM_LINE1 = 2;
  localparam int ITM_RESET = 5;
  localparam int ITM_OPEN = 2;
  localparam int ITM_CLOSE = 3;
  localparam int ITM_RELAY1 = 1;
  // Register map, byte addresses
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_TIMING0 = 12'h010;
  localparam logic [11:0] REG_PROG0 = 12'h040;
  localparam int ST_FAULT_BIT = 4;
  localparam int ST_OK_BIT = 5;
  localparam int ST_EMERG_BIT = 6;
  localparam int ST_COND_LSB = 8;
  localparam int TM_HOLD_LSB = 16;
  localparam logic [RELAYS-1:0] CTRL_RST = 4'h0;
  localparam logic [TIME_W-1:0] TIME_RST = 12'h000;
  localparam logic [31:0] PROG_RST [0:RELAYS-1] = '{32'h0000_2011, 32'h0000_3000,
                                                     32'h0000_2032, 32'h0000_3031};
  typedef enum logic [1:0] {RLY_IDLE, RLY_DELAY, RLY_ON, RLY_HOLD} srl_relay_state_type;
endpackage

// ==== srl_tick_gen.sv ====
// One-second tick divider.
// Assumes a free-running system clock; the period is a parameter.
`timescale 1ns/10ps
module srl_tick_gen
  import srl_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // One-cycle enable, once per second
  output logic tick
);
  logic [TICK_CNT_W-1:0] cnt_q;
  wire logic wrap = (cnt_q == TICK_CNT_W'(TICK_CYCLES_P - 1));
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
    begin
      cnt_q <= '0;
      tick <= 1'b0;
    end
    else
    begin
      cnt_q <= wrap ? '0 : cnt_q + 1'b1;
      tick <= wrap;
    end
endmodule

// ==== srl_cond_eval.sv ====
// Postfix condition evaluator for one relay.
// Assumes a flat table of two-valued status items, 16 per source.
`timescale 1ns/10ps
module srl_cond_eval
  import srl_pkg::*;
(
  // Program and status items
  input wire logic [PROG_W-1:0] prog,
  input wire logic [TAB_W-1:0] item_tab,
  // Two-valued result
  output logic result
);
  logic [INSNS-1:0] stk;
  logic [3:0] sp;
  logic done;
  logic [INSN_W-1:0] insn;
  logic [7:0] idx;
  logic term;
  // Postfix order gives grouping without a parser
  always_comb
  begin
    stk = '0;
    sp = 4'h0;
    done = 1'b0;
    insn = '0;
    idx = 8'h00;
    term = 1'b0;
    for (int i = 0; i < INSNS; i++)
    begin
      insn = prog[i*INSN_W +: INSN_W];
      idx = {insn[SRC_LSB +: 4], insn[ITEM_LSB +: 4]};
      term = ((idx < TAB_W) ? item_tab[idx] : 1'b0) ^ insn[NEG_BIT];
      if (!done)
      begin
        unique case (insn[OP_LSB +: 3])
          OP_END: done = 1'b1;
          OP_TERM:
            if (sp < 4'(INSNS))
            begin
              stk[sp[2:0]] = term;
              sp = sp + 4'h1;
            end
          OP_AND:
            if (sp >= 4'h2)
            begin
              stk[3'(sp - 4'h2)] = stk[3'(sp - 4'h2)] & stk[3'(sp - 4'h1)];
              sp = sp - 4'h1;
            end
          OP_OR:
            if (sp >= 4'h2)
            begin
              stk[3'(sp - 4'h2)] = stk[3'(sp - 4'h2)] | stk[3'(sp - 4'h1)];
              sp = sp - 4'h1;
            end
          OP_NOT:
            if (sp != 4'h0)
              stk[3'(sp - 4'h1)] = ~stk[3'(sp - 4'h1)];
          default: done = 1'b1;
        endcase
      end
    end
    // result is always 0 or 1
    result = (sp != 4'h0) & stk[0];
  end
endmodule

// ==== srl_status_relay.sv ====
// Top of the status relay logic unit: AHB-Lite registers, status item
// table, four condition evaluators and the per relay delay/hold timers.
// Assumes status inputs synchronous to mclk and a single AHB master.
`timescale 1ns/10ps
module srl_status_relay
  import srl_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Central module status
  input wire logic central_fail,
  input wire logic central_mains_fail,
  input wire logic wind_rain_signal,
  input wire logic [4:0] central_signal,
  // Sensor module status, one bit per module, three line alarm bits per module
  input wire logic [SENSORS-1:0] sensor_fail,
  input wire logic [SENSORS-1:0] sensor_alarm,
  input wire logic [3*SENSORS-1:0] sensor_line_alarm,
  input wire logic [SENSORS-1:0] sensor_reset,
  // Motor module status, one bit per module
  input wire logic [MOTORS-1:0] motor_fail,
  input wire logic [MOTORS-1:0] motor_alarm,
  input wire logic [MOTORS-1:0] motor_cmd_open,
  input wire logic [MOTORS-1:0] motor_cmd_close,
  // Power state
  input wire logic emergency_power,
  // Relays and indicators
  output logic [RELAYS-1:0] relay_contact,
  output logic [RELAYS-1:0] relay_led,
  output logic fault_led,
  output logic ok_led
);
  // Bus state
  logic wr_pend_q;
  logic rd_pend_q;
  logic [11:0] addr_q;
  // Configuration
  logic [RELAYS-1:0] drop_en_q;
  logic [TIME_W-1:0] delay_q [RELAYS];
  logic [TIME_W-1:0] hold_q [RELAYS];
  logic [31:0] prog_q [RELAYS*PROG_WORDS];
  // Relay machinery
  srl_relay_state_type state_q [RELAYS];
  srl_relay_state_type state_d [RELAYS];
  logic [TIME_W-1:0] cnt_q [RELAYS];
  logic [TIME_W-1:0] cnt_d [RELAYS];
  logic [RELAYS-1:0] relay_d;
  logic [RELAYS-1:0] cond_w;
  logic [RELAYS-1:0] cond_q;
  logic tick;
  logic [TAB_W-1:0] item_tab;

  srl_tick_gen #(
    .TICK_CYCLES_P(TICK_CYCLES_P)
  ) u_tick (
    .mclk(mclk),
    .arst_n(arst_n),
    .tick(tick)
  );

  // Bus address phase
  wire logic take = hsel & hready & htrans[1];
  wire logic take_wr = take & hwrite;
  wire logic take_rd = take & ~hwrite;

  // Register decode on the captured data-phase address
  wire logic hit_ctrl = (addr_q == REG_CTRL);
  wire logic hit_status = (addr_q == REG_STATUS);
  wire logic hit_timing = (addr_q[11:4] == REG_TIMING0[11:4]);
  wire logic hit_prog = (addr_q[11:6] == REG_PROG0[11:6]);
  wire logic [1:0] tm_idx = addr_q[3:2];
  wire logic [3:0] pg_idx = addr_q[5:2];
  wire logic wr_ctrl = wr_pend_q & hit_ctrl;
  wire logic wr_timing = wr_pend_q & hit_timing;
  wire logic wr_prog = wr_pend_q & hit_prog;

  // Out-of-range times saturate at one hour
  wire logic [TIME_W-1:0] wr_delay_raw = hwdata[TIME_W-1:0];
  wire logic [TIME_W-1:0] wr_hold_raw = hwdata[TM_HOLD_LSB +: TIME_W];
  wire logic [TIME_W-1:0] wr_delay = (wr_delay_raw > MAX_SECONDS) ? MAX_SECONDS : wr_delay_raw;
  wire logic [TIME_W-1:0] wr_hold = (wr_hold_raw > MAX_SECONDS) ? MAX_SECONDS : wr_hold_raw;

  // Status word shows the block's own state
  wire logic any_fail = central_fail | (|sensor_fail) | (|motor_fail);
  wire logic [31:0] status_word = {16'h0000, 4'h0, cond_q, 1'b0, emergency_power, ok_led,
                                   fault_led, relay_contact};
  wire logic [31:0] timing_word = {4'h0, hold_q[tm_idx], 4'h0, delay_q[tm_idx]};
  wire logic [31:0] rd_data = hit_ctrl ? {28'h0000000, drop_en_q} :
                              hit_status ? status_word :
                              hit_timing ? timing_word :
                              hit_prog ? prog_q[pg_idx] : 32'h0000_0000;

  // Reads take one wait state so a preceding write is always visible
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
    begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= 12'h000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_q <= take_wr;
      rd_pend_q <= take_rd;
      if (take)
        addr_q <= haddr[11:0];
      if (take_rd)
        hreadyout <= 1'b0;
      else if (rd_pend_q)
        hreadyout <= 1'b1;
      if (rd_pend_q)
        hrdata <= rd_data;
    end

  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
    begin
      drop_en_q <= CTRL_RST;
      for (int r = 0; r < RELAYS; r++)
      begin
        delay_q[r] <= TIME_RST;
        hold_q[r] <= TIME_RST;
      end
      for (int w = 0; w < RELAYS*PROG_WORDS; w++)
        prog_q[w] <= (w % PROG_WORDS == 0) ? PROG_RST[w / PROG_WORDS] : 32'h0000_0000;
    end
    else
    begin
      if (wr_ctrl)
        drop_en_q <= hwdata[RELAYS-1:0];
      if (wr_timing)
      begin
        delay_q[tm_idx] <= wr_delay;
        hold_q[tm_idx] <= wr_hold;
      end
      if (wr_prog)
        prog_q[pg_idx] <= hwdata;
    end

  // emergency forces OK and mains inactive
  wire logic fail_item = any_fail | emergency_power;
  wire logic mains_fail_item = central_mains_fail | emergency_power;

  // source slices of the item table
  wire logic [ITEMS-1:0] src_all = {15'h0000, fail_item};
  // Class lines are the OR of the same line over every sensor
  wire logic [2:0] line_any = sensor_line_alarm[2:0] | sensor_line_alarm[5:3];
  wire logic [ITEMS-1:0] src_all_sensor = {10'h000, |sensor_reset, line_any,
                                           |sensor_alarm, |sensor_fail};
  wire logic [ITEMS-1:0] src_all_motor = {12'h000, |motor_cmd_close, |motor_cmd_open,
                                          |motor_alarm, |motor_fail};
  wire logic [ITEMS-1:0] src_central = {8'h00, central_signal, wind_rain_signal,
                                        mains_fail_item, central_fail};
  wire logic [ITEMS-1:0] src_msg = {11'h000, relay_contact, 1'b0};
  logic [ITEMS-1:0] src_sensor [SENSORS];
  logic [ITEMS-1:0] src_motor [MOTORS];

  genvar g;
  generate
    for (g = 0; g < SENSORS; g++)
    begin : g_sensor
      assign src_sensor[g] = {10'h000, sensor_reset[g], sensor_line_alarm[3*g +: 3],
                              sensor_alarm[g], sensor_fail[g]};
    end
    for (g = 0; g < MOTORS; g++)
    begin : g_motor
      assign src_motor[g] = {12'h000, motor_cmd_close[g], motor_cmd_open[g],
                             motor_alarm[g], motor_fail[g]};
    end
  endgenerate

  assign item_tab = {src_msg, src_motor[1], src_motor[0], src_sensor[1], src_sensor[0],
                     src_central, src_all_motor, src_all_sensor, src_all};

  generate
    for (g = 0; g < RELAYS; g++)
    begin : g_relay
      wire logic [PROG_W-1:0] prog_flat = {prog_q[g*PROG_WORDS+3], prog_q[g*PROG_WORDS+2],
                                           prog_q[g*PROG_WORDS+1], prog_q[g*PROG_WORDS]};
      srl_cond_eval u_eval (
        .prog(prog_flat),
        .item_tab(item_tab),
        .result(cond_w[g])
      );
      wire logic drop = emergency_power & drop_en_q[g];
      wire logic active = cond_q[g] & ~drop;
      wire logic [TIME_W-1:0] cnt_inc = cnt_q[g] + 12'h001;
      wire logic zero_hold = (hold_q[g] == TIME_RST);

      always_comb
      begin
        state_d[g] = state_q[g];
        cnt_d[g] = cnt_q[g];
        unique case (state_q[g])
          RLY_IDLE:
            if (active)
            begin
              cnt_d[g] = TIME_RST;
              if (delay_q[g] == TIME_RST)
                state_d[g] = zero_hold ? RLY_ON : RLY_HOLD;
              else
                state_d[g] = RLY_DELAY;
            end
          RLY_DELAY:
            // condition must hold the whole delay
            if (!active)
              state_d[g] = RLY_IDLE;
            else if (tick)
            begin
              cnt_d[g] = cnt_inc;
              if (cnt_inc >= delay_q[g])
              begin
                cnt_d[g] = TIME_RST;
                state_d[g] = zero_hold ? RLY_ON : RLY_HOLD;
              end
            end
          RLY_ON:
            // follow condition when hold is unlimited
            if (!active)
              state_d[g] = RLY_IDLE;
          RLY_HOLD:
            if (drop)
              state_d[g] = RLY_IDLE;
            else if (tick)
            begin
              cnt_d[g] = cnt_inc;
              if (cnt_inc >= hold_q[g])
                state_d[g] = RLY_IDLE;
            end
        endcase
      end

      // contact is strictly on or off
      assign relay_d[g] = (state_d[g] == RLY_ON) | (state_d[g] == RLY_HOLD);
    end
  endgenerate

  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
    begin
      for (int r = 0; r < RELAYS; r++)
      begin
        state_q[r] <= RLY_IDLE;
        cnt_q[r] <= TIME_RST;
      end
      cond_q <= '0;
    end
    else
    begin
      for (int r = 0; r < RELAYS; r++)
      begin
        state_q[r] <= state_d[r];
        cnt_q[r] <= cnt_d[r];
      end
      cond_q <= cond_w;
    end

  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
    begin
      relay_contact <= '0;
      relay_led <= '0;
      fault_led <= 1'b0;
      ok_led <= 1'b0;
    end
    else
    begin
      relay_contact <= relay_d;
      relay_led <= relay_d;
      fault_led <= any_fail;
      ok_led <= ~any_fail;
    end
endmodule

// ==== srl_contact_mon.sv ====
// Model of the signalling equipment wired to the four relay contacts.
// Assumes the contacts are sampled on the system clock.
`timescale 1ns/10ps
module srl_contact_mon
  import srl_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Dry contacts
  input wire logic [RELAYS-1:0] contact,
  // Closures seen per relay, 8 bits each
  output logic [8*RELAYS-1:0] closures
);
  logic [RELAYS-1:0] prev_q;
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      prev_q <= '0;
      closures <= '0;
    end
    else
    begin
      prev_q <= contact;
      for (int i = 0; i < RELAYS; i++)
        if (contact[i] && !prev_q[i])
          closures[8*i+:8] <= closures[8*i+:8] + 8'h01;
    end
  end
endmodule

// ==== srl_status_relay_chk.sv ====
// Port checker of the status relay unit.
// Assumes one AHB master with hready fed from hreadyout.
`timescale 1ns/10ps
module srl_status_relay_chk
  import srl_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // Status and outputs
  input wire logic central_fail,
  input wire logic [SENSORS-1:0] sensor_fail,
  input wire logic [MOTORS-1:0] motor_fail,
  input wire logic [RELAYS-1:0] relay_contact,
  input wire logic [RELAYS-1:0] relay_led,
  input wire logic fault_led,
  input wire logic ok_led
);
  logic up_q;
  wire taken = hsel & hready & htrans[1];
  wire any_fail = central_fail | (|sensor_fail) | (|motor_fail);
  // First edge after release still shows reset values
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      up_q <= 1'b0;
    else
      up_q <= 1'b1;
  end
  default clocking dcb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("hresp not OKAY");
  a_write_no_wait: assert property (taken && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  a_read_one_wait: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_rdata_holds: assert property ($changed(hrdata) |-> $rose(hreadyout))
    else $error("hrdata changed outside read end");
  a_led_copy: assert property (relay_led == relay_contact)
    else $error("relay indicator differs from contact");
  a_fault_led: assert property (up_q |-> fault_led == $past(any_fail))
    else $error("fault indicator wrong");
  a_ok_led: assert property (up_q |-> ok_led == !$past(any_fail))
    else $error("ok indicator wrong");
  a_reset_clear: assert property (!up_q |-> relay_contact == 4'h0 && !ok_led)
    else $error("outputs not cleared by reset");
endmodule

bind srl_status_relay srl_status_relay_chk #(.TICK_CYCLES_P(TICK_CYCLES_P))
  i_srl_status_relay_chk (
  .mclk(mclk), .arst_n(arst_n), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .central_fail(central_fail), .sensor_fail(sensor_fail), .motor_fail(motor_fail),
  .relay_contact(relay_contact), .relay_led(relay_led), .fault_led(fault_led),
  .ok_led(ok_led)
);

// ==== tb.sv ====
// Self-checking bench of the status relay unit.
// Assumes a shortened tick of 10 cycles per second.
`timescale 1ns/10ps
module tb;
  import srl_pkg::*;
  localparam int TK = 10;
  localparam int CF = 0, MF = 1, WD = 2, SF = 3, SA = 5, LA = 7, MA = 13, MO = 15, EM = 17;
  logic mclk;
  logic arst_n;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [31:0] hwdata;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [17:0] st;
  logic [RELAYS-1:0] relay_contact;
  logic [RELAYS-1:0] relay_led;
  logic fault_led;
  logic ok_led;
  logic [8*RELAYS-1:0] closures;
  logic [31:0] rd;
  logic [7:0] n0;
  logic r1;
  int miscompares;
  int checks_done;

  srl_status_relay #(.TICK_CYCLES_P(TK)) i_srl_status_relay (
    .mclk(mclk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .central_fail(st[CF]), .central_mains_fail(st[MF]), .wind_rain_signal(st[WD]),
    .central_signal(5'h00), .sensor_fail(st[SF+:2]), .sensor_alarm(st[SA+:2]),
    .sensor_line_alarm(st[LA+:6]), .sensor_reset(2'h0), .motor_fail(2'h0),
    .motor_alarm(st[MA+:2]), .motor_cmd_open(st[MO+:2]), .motor_cmd_close(2'h0),
    .emergency_power(st[EM]), .relay_contact(relay_contact), .relay_led(relay_led),
    .fault_led(fault_led), .ok_led(ok_led)
  );
  srl_contact_mon i_srl_contact_mon (
    .mclk(mclk), .arst_n(arst_n), .contact(relay_contact), .closures(closures)
  );

  task automatic finish_test;
    if (miscompares == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // Bounded wait for the slave; a hang ends the run
  task automatic wait_rdy;
    int n;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1)
    begin
      miscompares++;
      finish_test;
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h00000, a};
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    rd = hrdata;
  endtask
  task automatic chk_rd(input logic [11:0] a, input logic [31:0] exp, input string what);
    xfer(1'b0, a, 32'h0);
    cmp(what, rd, exp);
  endtask
  task automatic wait_relay(input int r, input logic v);
    int n;
    n = 0;
    while (relay_contact[r] !== v && n < 80)
    begin
      @(posedge mclk);
      n++;
    end
    if (relay_contact[r] !== v)
    begin
      miscompares++;
      finish_test;
    end
  endtask

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial
  begin
    miscompares = 0;
    checks_done = 0;
    arst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    st = '0;
    cyc(5);
    arst_n <= 1'b1;
    cyc(3);
    cmp("relays", 32'(relay_contact), 32'hA);
    chk_rd(REG_STATUS, 32'h0000_0A2A, "status");
    chk_rd(REG_CTRL, 32'h0, "ctrl");
    for (int r = 0; r < RELAYS; r++)
    begin
      chk_rd(REG_PROG0 + 12'(16 * r), PROG_RST[r], "prog");
      chk_rd(REG_TIMING0 + 12'(4 * r), 32'h0, "timing");
    end
    // Unmapped place ignores writes
    xfer(1'b1, 12'h008, 32'hFFFF_FFFF);
    chk_rd(12'h008, 32'h0, "unmapped");
    st[SA+1] <= 1'b1;
    st[WD] <= 1'b1;
    st[MF] <= 1'b1;
    st[SF] <= 1'b1;
    cyc(3);
    cmp("relays", 32'(relay_contact), 32'h5);
    cmp("leds", 32'({fault_led, ok_led}), 32'h2);
    st <= '0;
    cyc(2);
    st[EM] <= 1'b1;
    st[SA] <= 1'b1;
    st[WD] <= 1'b1;
    cyc(3);
    cmp("emergency", 32'(relay_contact), 32'h5);
    xfer(1'b1, REG_CTRL, 32'h1);
    cyc(3);
    cmp("drop out", 32'(relay_contact), 32'h4);
    st[EM] <= 1'b0;
    cyc(3);
    cmp("mains back", 32'(relay_contact), 32'hF);
    st <= '0;
    xfer(1'b1, REG_CTRL, 32'h0);
    // Line 1 and not lines 2 or 3; doubled negation; class and instance; relay-on item
    xfer(1'b1, REG_PROG0, 32'h2043_2042);
    xfer(1'b1, REG_PROG0 + 12'h004, 32'h6000_2044);
    xfer(1'b1, REG_PROG0 + 12'h008, 32'h4000_8000);
    xfer(1'b1, REG_PROG0 + 12'h010, 32'h8000_3032);
    xfer(1'b1, REG_PROG0 + 12'h020, 32'h2072_2021);
    xfer(1'b1, REG_PROG0 + 12'h024, 32'h0000_6000);
    xfer(1'b1, REG_PROG0 + 12'h030, 32'h0000_2081);
    for (int i = 0; i < 8; i++)
    begin
      st[LA+:3] <= i[2:0];
      st[WD] <= i[0];
      st[MA] <= i[1];
      st[MO+1] <= i[2];
      r1 = i[0] & !(i[1] | i[2]);
      cyc(6);
      cmp("logic", 32'(relay_contact), 32'({r1, i[1] | i[2], i[0], r1}));
    end
    st <= '0;
    xfer(1'b1, REG_TIMING0 + 12'h004, 32'h0FFF_0FFF);
    chk_rd(REG_TIMING0 + 12'h004, 32'h0E10_0E10, "saturate");
    xfer(1'b1, REG_TIMING0, 32'h0000_0002);
    n0 = closures[7:0];
    // Too short a true spell must not switch
    st[LA] <= 1'b1;
    cyc(5);
    st[LA] <= 1'b0;
    cyc(30);
    cmp("short spell", 32'(closures[7:0] - n0), 32'h0);
    st[LA] <= 1'b1;
    cyc(8);
    cmp("delay running", 32'(relay_contact[0]), 32'h0);
    wait_relay(0, 1'b1);
    xfer(1'b1, REG_TIMING0, 32'h0003_0000);
    st[LA] <= 1'b0;
    cyc(4);
    cmp("follows", 32'(relay_contact[0]), 32'h0);
    n0 = closures[7:0];
    st[LA] <= 1'b1;
    cyc(2);
    st[LA] <= 1'b0;
    cyc(15);
    cmp("holding", 32'(relay_contact[0]), 32'h1);
    wait_relay(0, 1'b0);
    cmp("closures", 32'(closures[7:0] - n0), 32'h1);
    st[LA] <= 1'b1;
    cyc(4);
    arst_n <= 1'b0;
    cyc(1);
    cmp("in reset", 32'(relay_contact), 32'h0);
    st <= '0;
    cyc(2);
    arst_n <= 1'b1;
    cyc(3);
    chk_rd(REG_TIMING0, 32'h0, "timing cleared");
    cmp("relays", 32'(relay_contact), 32'hA);
    finish_test;
  end
endmodule
